// ### hw/imc_pkg.sv
// constants for the indirect extended-register access bank
// assumes a 16-bit management register space with 5-bit register numbers
package imc_pkg;

  // ----------------------------------------------------------------
  // register numbers within the management space
  // ----------------------------------------------------------------
  localparam logic [4:0] IMC_OFF_CTRL = 5'h0d;
  localparam logic [4:0] IMC_OFF_DATA = 5'h0e;
  localparam logic [4:0] IMC_OFF_ESTAT = 5'h0f;

  // ----------------------------------------------------------------
  // field layout and reset values
  // ----------------------------------------------------------------
  localparam int IMC_MODE_HI = 15;
  localparam int IMC_MODE_LO = 14;
  localparam int IMC_DEV_HI = 4;
  localparam int IMC_DEV_LO = 0;
  localparam int IMC_DEV_CNT = 32;
  localparam logic [15:0] IMC_CTRL_RST = 16'h0000;
  localparam logic [15:0] IMC_ADDR_RST = 16'h0000;
  localparam logic [15:0] IMC_WORD_ZERO = 16'h0000;
  localparam logic [15:0] IMC_ADDR_STEP = 16'h0001;
  // 1000base-x fd/hd = 0, 1000base-t fd/hd = 1, low bits read zero
  localparam logic [15:0] IMC_ESTAT_VAL = 16'h3000;

  // ----------------------------------------------------------------
  // operation modes of the companion register
  // ----------------------------------------------------------------
  typedef enum logic [1:0]
  {
    IMC_MODE_REG = 2'h0,
    IMC_MODE_DATA = 2'h1,
    IMC_MODE_INC_RW = 2'h2,
    IMC_MODE_INC_WR = 2'h3
  } imc_mode_t;

endpackage : imc_pkg

// ### hw/imc_addr_if.sv
// carrier between the access bank and its per-device address store
// assumes both ends sit on the same management clock
interface imc_addr_if;
  import imc_pkg::*;

  logic [4:0] dev; // selected extended device
  logic load; // write a new held address
  logic incr; // advance the held address
  logic [15:0] load_val; // address to load
  logic [15:0] held_addr; // held address of selected device

  modport bank (output dev, output load, output incr, output load_val, input held_addr);
  modport store (input dev, input load, input incr, input load_val, output held_addr);
endinterface : imc_addr_if

// ### hw/imc_addr_store.sv
// held register address for each of the 32 extended devices
// assumes load and incr are never requested together
module imc_addr_store
  import imc_pkg::*;
(
  input wire logic clk_sys, // management clock
  input wire logic resetn, // async reset, active low
  imc_addr_if.store aif // requests from the access bank
);
  import imc_pkg::*;

  logic [15:0] addr_reg [IMC_DEV_CNT];
  logic [15:0] addr_next [IMC_DEV_CNT];

  // ----------------------------------------------------------------
  // one address word per device
  // ----------------------------------------------------------------
  for (genvar i = 0; i < IMC_DEV_CNT; i++)
  begin : g_dev
    // load in register mode, step by one on post-increment
    always_comb
    begin
      addr_next[i] = addr_reg[i];
      if (aif.dev == 5'(i) && aif.load)
      begin
        addr_next[i] = aif.load_val;
      end
      else if (aif.dev == 5'(i) && aif.incr)
      begin
        addr_next[i] = addr_reg[i] + IMC_ADDR_STEP;
      end
    end

    always_ff @(posedge clk_sys or negedge resetn)
    begin
      if (!resetn)
        addr_reg[i] <= IMC_ADDR_RST;
      else
        addr_reg[i] <= addr_next[i];
    end
  end

  // combinational view of the selected device's address
  assign aif.held_addr = addr_reg[aif.dev];

endmodule : imc_addr_store

// ### hw/imc_access_bank.sv
// indirect access bank: control, register/data and extended status words
// assumes a management frame decoder that gives one-cycle read/write strobes
// and an extended register space that answers mmd_rdata in the read cycle
module imc_access_bank
  import imc_pkg::*;
(
  input wire logic clk_sys, // management clock, 10 mhz
  input wire logic resetn, // async reset, active low
  input wire logic [4:0] mgmt_addr, // register number of the access
  input wire logic mgmt_wr, // write strobe, one cycle
  input wire logic mgmt_rd, // read strobe, one cycle
  input wire logic [15:0] mgmt_wdata, // write data
  output logic [15:0] mgmt_rdata, // read answer
  output logic mgmt_rvalid, // read answer valid, one cycle
  output logic [4:0] mmd_dev, // extended device of the access
  output logic [15:0] mmd_addr, // extended register address
  output logic mmd_wr, // extended write pulse
  output logic mmd_rd, // extended read pulse
  output logic [15:0] mmd_wdata, // extended write data
  input wire logic [15:0] mmd_rdata // extended read data, same cycle as mmd_rd
);
  import imc_pkg::*;

  imc_addr_if aif ();

  logic [15:0] ctrl_reg;
  logic [15:0] ctrl_next;
  logic rd_pend_reg;
  logic rd_pend_next;
  logic [4:0] rd_sel_reg;
  logic [4:0] rd_sel_next;
  logic [15:0] rdata_reg;
  logic [15:0] rdata_next;
  logic rvalid_reg;
  logic rvalid_next;
  logic [4:0] mmd_dev_reg;
  logic [4:0] mmd_dev_next;
  logic [15:0] mmd_addr_reg;
  logic [15:0] mmd_addr_next;
  logic mmd_wr_reg;
  logic mmd_wr_next;
  logic mmd_rd_reg;
  logic mmd_rd_next;
  logic [15:0] mmd_wdata_reg;
  logic [15:0] mmd_wdata_next;
  imc_mode_t mode;
  logic rd_take;
  logic hit_ctrl;
  logic hit_data;
  logic data_mode;
  logic step_wr;
  logic step_rd;

  // ----------------------------------------------------------------
  // field decode
  // ----------------------------------------------------------------
  assign mode = imc_mode_t'(ctrl_reg[IMC_MODE_HI:IMC_MODE_LO]);
  assign aif.dev = ctrl_reg[IMC_DEV_HI:IMC_DEV_LO];

  imc_addr_store u_store
  (
    .clk_sys (clk_sys),
    .resetn (resetn),
    .aif (aif.store)
  );

  // ----------------------------------------------------------------
  // request decode
  // ----------------------------------------------------------------
  // a read that meets a write is dropped; the frame decoder never issues
  // both, so nothing is lost in practice
  assign rd_take = mgmt_rd && !mgmt_wr;
  assign hit_ctrl = (mgmt_addr == IMC_OFF_CTRL);
  assign hit_data = (mgmt_addr == IMC_OFF_DATA);
  assign data_mode = (mode != IMC_MODE_REG);
  // the held address steps only after the access that used it
  assign step_wr = (mode == IMC_MODE_INC_RW) || (mode == IMC_MODE_INC_WR);
  assign step_rd = (mode == IMC_MODE_INC_RW);

  // ----------------------------------------------------------------
  // control word
  // ----------------------------------------------------------------
  // reserved bits 13:5 are kept as written so the host reads back its word
  always_comb
  begin
    ctrl_next = ctrl_reg;
    if (mgmt_wr && hit_ctrl)
    begin
      ctrl_next = mgmt_wdata;
    end
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
      ctrl_reg <= IMC_CTRL_RST;
    else
      ctrl_reg <= ctrl_next;
  end

  // ----------------------------------------------------------------
  // extended access and held address
  // ----------------------------------------------------------------
  // relies on the host loading the address first; a device that was
  // never loaded simply starts from address zero
  always_comb
  begin
    mmd_dev_next = mmd_dev_reg;
    mmd_addr_next = mmd_addr_reg;
    mmd_wr_next = 1'b0;
    mmd_rd_next = 1'b0;
    mmd_wdata_next = mmd_wdata_reg;
    aif.load = 1'b0;
    aif.incr = 1'b0;
    aif.load_val = mgmt_wdata;
    if (mgmt_wr && hit_data && !data_mode)
    begin
      aif.load = 1'b1;
    end
    else if (mgmt_wr && hit_data)
    begin
      mmd_wr_next = 1'b1;
      mmd_dev_next = aif.dev;
      mmd_addr_next = aif.held_addr;
      mmd_wdata_next = mgmt_wdata;
      aif.incr = step_wr;
    end
    else if (rd_take && hit_data && data_mode)
    begin
      mmd_rd_next = 1'b1;
      mmd_dev_next = aif.dev;
      mmd_addr_next = aif.held_addr;
      aif.incr = step_rd;
    end
  end

  // registered so the extended space sees one clean pulse per access
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      mmd_dev_reg <= IMC_CTRL_RST[IMC_DEV_HI:IMC_DEV_LO];
      mmd_addr_reg <= IMC_ADDR_RST;
      mmd_wr_reg <= 1'b0;
      mmd_rd_reg <= 1'b0;
      mmd_wdata_reg <= IMC_WORD_ZERO;
    end
    else
    begin
      mmd_dev_reg <= mmd_dev_next;
      mmd_addr_reg <= mmd_addr_next;
      mmd_wr_reg <= mmd_wr_next;
      mmd_rd_reg <= mmd_rd_next;
      mmd_wdata_reg <= mmd_wdata_next;
    end
  end

  // ----------------------------------------------------------------
  // read answer
  // ----------------------------------------------------------------
  // the answer is built one cycle after the strobe, while the extended
  // read pulse stands and its data is valid
  always_comb
  begin
    rd_pend_next = rd_take;
    rd_sel_next = rd_sel_reg;
    rdata_next = rdata_reg;
    rvalid_next = 1'b0;
    if (rd_take)
      rd_sel_next = mgmt_addr;
    if (rd_pend_reg)
    begin
      rvalid_next = 1'b1;
      if (rd_sel_reg == IMC_OFF_CTRL)
        rdata_next = ctrl_reg;
      else if (rd_sel_reg == IMC_OFF_DATA && mmd_rd_reg)
        rdata_next = mmd_rdata;
      else if (rd_sel_reg == IMC_OFF_DATA)
        rdata_next = aif.held_addr;
      else if (rd_sel_reg == IMC_OFF_ESTAT)
        rdata_next = IMC_ESTAT_VAL;
      else
        rdata_next = IMC_WORD_ZERO; // other numbers belong to other banks
    end
  end

  // all answer outputs come from here so the frame decoder sees clean timing
  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      rd_pend_reg <= 1'b0;
      rd_sel_reg <= IMC_OFF_CTRL;
      rdata_reg <= IMC_WORD_ZERO;
      rvalid_reg <= 1'b0;
    end
    else
    begin
      rd_pend_reg <= rd_pend_next;
      rd_sel_reg <= rd_sel_next;
      rdata_reg <= rdata_next;
      rvalid_reg <= rvalid_next;
    end
  end

  // output wiring
  assign mgmt_rdata = rdata_reg;
  assign mgmt_rvalid = rvalid_reg;
  assign mmd_dev = mmd_dev_reg;
  assign mmd_addr = mmd_addr_reg;
  assign mmd_wr = mmd_wr_reg;
  assign mmd_rd = mmd_rd_reg;
  assign mmd_wdata = mmd_wdata_reg;

endmodule : imc_access_bank

// ### verification/imc_properties.sv
// checker for the indirect access bank, bound to its ports
// assumes one clock domain and the async active-low reset
module imc_properties
  import imc_pkg::*;
(
  input wire logic clk_sys, // clock
  input wire logic resetn, // reset
  input wire logic [4:0] mgmt_addr, // reg number
  input wire logic mgmt_wr, // write
  input wire logic mgmt_rd, // read
  input wire logic [15:0] mgmt_wdata, // data in
  input wire logic [15:0] mgmt_rdata, // answer
  input wire logic mgmt_rvalid, // answer valid
  input wire logic [4:0] mmd_dev, // device
  input wire logic [15:0] mmd_addr, // ext address
  input wire logic mmd_wr, // ext write
  input wire logic mmd_rd, // ext read
  input wire logic [15:0] mmd_wdata // ext data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] c_reg, cd_reg, la_reg;
  logic [4:0] ld_reg;
  logic lv_reg, li_reg, ld0, rdq, px;
  assign rdq = mgmt_rd && !mgmt_wr;
  assign px = mmd_wr || mmd_rd;
  assign ld0 = mgmt_wr && mgmt_addr == IMC_OFF_DATA && c_reg[15:14] == 2'h0;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  // control shadow, delayed a cycle so it lines up with the ext pulses
  always_ff @(posedge clk_sys or negedge resetn)
    if (!resetn)
    begin
      {c_reg, cd_reg, la_reg, ld_reg, lv_reg, li_reg} <= '0;
    end
    else
    begin
      if (mgmt_wr && mgmt_addr == IMC_OFF_CTRL) c_reg <= mgmt_wdata;
      cd_reg <= c_reg;
      // a reload breaks the address chain, so stop comparing
      if (ld0) lv_reg <= 1'b0;
      else if (px)
      begin
        lv_reg <= 1'b1;
        la_reg <= mmd_addr;
        ld_reg <= mmd_dev;
        li_reg <= cd_reg[15:14] == 2'h2 || (cd_reg[15:14] == 2'h3 && mmd_wr);
      end
    end
  a_read_two_late: assert property (rdq |-> ##2 mgmt_rvalid)
    else $error("read answer late");
  a_no_spur_valid: assert property (!rdq |-> ##2 !mgmt_rvalid)
    else $error("answer without read");
  a_reg_mode_quiet: assert property ((mgmt_wr || rdq) && mgmt_addr == IMC_OFF_DATA
    && c_reg[15:14] == 2'h0 |=> !px) else $error("ext access in register mode");
  a_data_wr_pass: assert property (mgmt_wr && mgmt_addr == IMC_OFF_DATA
    && c_reg[15:14] != 2'h0 |=> mmd_wr && mmd_wdata == $past(mgmt_wdata))
    else $error("ext write missing");
  a_data_rd_pass: assert property (rdq && mgmt_addr == IMC_OFF_DATA
    && c_reg[15:14] != 2'h0 |=> mmd_rd && !mmd_wr) else $error("ext read missing");
  a_dev_select: assert property (px |-> mmd_dev == cd_reg[4:0])
    else $error("wrong device");
  a_addr_step: assert property (px && lv_reg && mmd_dev == ld_reg
    |-> mmd_addr == la_reg + {15'h0000, li_reg}) else $error("address step wrong");
  a_estat_base_t: assert property (rdq && mgmt_addr == IMC_OFF_ESTAT
    |-> ##2 mgmt_rdata[13:12] == 2'b11) else $error("base-t bits wrong");
  a_estat_base_x: assert property (rdq && mgmt_addr == IMC_OFF_ESTAT
    |-> ##2 mgmt_rdata[15:14] == 2'b00) else $error("base-x bits wrong");
endmodule : imc_properties

bind imc_access_bank imc_properties u_props (.clk_sys(clk_sys), .resetn(resetn),
  .mgmt_addr(mgmt_addr), .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata),
  .mgmt_rdata(mgmt_rdata), .mgmt_rvalid(mgmt_rvalid), .mmd_dev(mmd_dev),
  .mmd_addr(mmd_addr), .mmd_wr(mmd_wr), .mmd_rd(mmd_rd), .mmd_wdata(mmd_wdata));

// ### verification/imc_mmd_model.sv
// extended register space behind the bank
// assumes mmd_rdata is used only while mmd_rd is high
module imc_mmd_model
(
  input wire logic clk_sys, // clock
  input wire logic [4:0] mmd_dev, // device
  input wire logic [15:0] mmd_addr, // address
  input wire logic mmd_wr, // write pulse
  input wire logic mmd_rd, // read pulse
  input wire logic [15:0] mmd_wdata, // write data
  output logic [15:0] mmd_rdata // read data
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [15:0] mem [logic [20:0]];
  // blocking store so a read in the next cycle sees it
  always @(posedge clk_sys)
    if (mmd_wr) mem[{mmd_dev, mmd_addr}] = mmd_wdata;
  // unwritten places read zero; outside a read the bus shows the inverse
  always @*
    mmd_rdata = (mem.exists({mmd_dev, mmd_addr}) ? mem[{mmd_dev, mmd_addr}] : 16'h0000)
      ^ {16{!mmd_rd}};
endmodule : imc_mmd_model

// ### verification/testbench.sv
// self-checking bench for the indirect access bank
// assumes the model answers inside the ext read pulse
module testbench
  import imc_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clk_sys = 1'b0, resetn = 1'b0, mgmt_wr = 1'b0, mgmt_rd = 1'b0, mgmt_rvalid;
  logic mmd_wr, mmd_rd;
  logic [4:0] mgmt_addr = 5'h00, mmd_dev;
  logic [15:0] mgmt_wdata = 16'h0000, mgmt_rdata, mmd_addr, mmd_wdata, mmd_rdata;
  logic [15:0] ctl = 16'h0000, held [32], mem [int];
  int err_total = 0, n_compared = 0;
  always #50 clk_sys = ~clk_sys;
  imc_access_bank u_dut (.clk_sys(clk_sys), .resetn(resetn), .mgmt_addr(mgmt_addr),
    .mgmt_wr(mgmt_wr), .mgmt_rd(mgmt_rd), .mgmt_wdata(mgmt_wdata), .mgmt_rdata(mgmt_rdata),
    .mgmt_rvalid(mgmt_rvalid), .mmd_dev(mmd_dev), .mmd_addr(mmd_addr), .mmd_wr(mmd_wr),
    .mmd_rd(mmd_rd), .mmd_wdata(mmd_wdata), .mmd_rdata(mmd_rdata));
  imc_mmd_model u_mmd (.clk_sys(clk_sys), .mmd_dev(mmd_dev), .mmd_addr(mmd_addr),
    .mmd_wr(mmd_wr), .mmd_rd(mmd_rd), .mmd_wdata(mmd_wdata), .mmd_rdata(mmd_rdata));
  task automatic wrap_up;
    if (err_total == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : wrap_up
  // read answer against the reference value, looked at while valid stands
  task automatic cmp_read(input logic [15:0] e);
    n_compared++;
    if (mgmt_rvalid !== 1'b1 || mgmt_rdata !== e)
    begin
      err_total++;
      $display("mismatch %0t got %h expected %h", $time, mgmt_rdata, e);
    end
  endtask : cmp_read
  // one access, mirrored in the reference model, read answers compared
  task automatic acc(input bit w, input logic [4:0] a, input logic [15:0] d);
    logic [15:0] e;
    logic [4:0] v;
    e = 16'h0000;
    v = ctl[4:0];
    if (a == IMC_OFF_CTRL)
    begin
      if (w) ctl = d;
      e = ctl;
    end
    else if (a == IMC_OFF_ESTAT) e = {2'b00, 2'b11, 12'h000};
    else if (a == IMC_OFF_DATA && ctl[15:14] == 2'h0)
    begin
      if (w) held[v] = d;
      e = held[v];
    end
    else if (a == IMC_OFF_DATA)
    begin
      if (w) mem[{v, held[v]}] = d;
      e = mem.exists({v, held[v]}) ? mem[{v, held[v]}] : 16'h0000;
      if (ctl[15:14] == 2'h2 || (ctl[15:14] == 2'h3 && w)) held[v] = held[v] + 16'h0001;
    end
    mgmt_wr = w;
    mgmt_rd = !w;
    mgmt_addr = a;
    mgmt_wdata = d;
    @(negedge clk_sys);
    mgmt_wr = 1'b0;
    mgmt_rd = 1'b0;
    // the answer stands only in the cycle after the next rising edge
    @(negedge clk_sys);
    if (!w) cmp_read(e);
  endtask : acc
  // main sequence: all four modes, random devices, wrap at the top address
  initial
  begin
    logic [4:0] v;
    logic [15:0] b;
    void'($urandom(32'haece));
    foreach (held[i]) held[i] = 16'h0000;
    repeat (10) @(negedge clk_sys);
    resetn = 1'b1;
    acc(0, IMC_OFF_CTRL, 16'h0000);
    acc(0, IMC_OFF_DATA, 16'h0000);
    acc(1, IMC_OFF_ESTAT, 16'hffff);
    acc(0, IMC_OFF_ESTAT, 16'h0000);
    acc(0, 5'h10, 16'h0000);
    for (int k = 0; k < 16; k++)
    begin
      v = 5'($urandom);
      b = k < 8 ? 16'hfffe : 16'($urandom);
      acc(1, IMC_OFF_CTRL, {11'h000, v});
      acc(1, IMC_OFF_DATA, b);
      acc(1, IMC_OFF_CTRL, {2'(k), 9'($urandom), v});
      acc(0, IMC_OFF_CTRL, 16'h0000);
      repeat (3)
      begin
        acc(1, IMC_OFF_DATA, 16'($urandom));
        acc(0, IMC_OFF_DATA, 16'h0000);
      end
      acc(1, IMC_OFF_CTRL, {11'h000, v});
      acc(0, IMC_OFF_DATA, 16'h0000);
      acc(1, IMC_OFF_DATA, b);
      acc(1, IMC_OFF_CTRL, {2'h2, 9'h000, v});
      repeat (6) acc(0, IMC_OFF_DATA, 16'h0000);
    end
    wrap_up();
  end
  // about thirty times the expected run, cuts a hang short
  initial
  begin
    #2000000;
    err_total++;
    wrap_up();
  end
endmodule : testbench
